// ===== common/tbcc_pkg.sv
// Package for the timer B capture/compare block: register map, fields, modes
package tbcc_pkg;
   // Register byte offsets (word aligned)
   localparam logic [7:0] ADDR_CTRL_FIRST = 8'h00;
   localparam logic [7:0] ADDR_CTRL_SECOND = 8'h04;
   localparam logic [7:0] ADDR_EVENT_CTRL = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0c;
   localparam logic [7:0] ADDR_FLAGS = 8'h10;
   localparam logic [7:0] ADDR_COUNT = 8'h14;
   localparam logic [7:0] ADDR_COMPARE_CAPTURE_VALUE = 8'h18;
   // Field positions
   localparam int CF_ENABLE_BIT = 0;
   localparam int CF_CLOCK_SOURCE_SELECT_LSB = 1;
   localparam int CS_MODE_LSB = 0;
   localparam int CS_WAVE_EN_BIT = 4;
   localparam int CS_WAVE_INIT_BIT = 5;
   localparam int EC_EDGE_BIT = 4;
   localparam int ST_RUN_BIT = 0;
   localparam int FL_CAPTURE_FLAG_BIT = 0;
   // Reset values, count limits and mode count
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] COMPARE_CAPTURE_VALUE_RESET = 16'h0000;
   localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
   localparam logic [15:0] COUNT_MAX = 16'hffff;
   localparam int MODE_COUNT = 8;

   typedef enum logic [2:0] {
      TBCC_MODE_PERIODIC = 3'b000,
      TBCC_MODE_TIMEOUT = 3'b001,
      TBCC_MODE_CAPTURE_FLAG_EVT = 3'b010,
      TBCC_MODE_CAPTURE_FLAG_FRQ = 3'b011,
      TBCC_MODE_CAPTURE_FLAG_PW = 3'b100,
      TBCC_MODE_CAPTURE_FLAG_FPW = 3'b101,
      TBCC_MODE_SINGLE = 3'b110,
      TBCC_MODE_PWM8 = 3'b111
   } tbcc_mode_t;

   typedef enum logic [1:0] {
      TBCC_PERIPHERAL_CLOCK = 2'b00,
      TBCC_PERIPHERAL_CLOCK_DIV2 = 2'b01,
      TBCC_CLK_PARTNER = 2'b10,
      TBCC_CLK_RSVD = 2'b11
   } tbcc_clock_source_select_t;

   // APB request bundle
   typedef struct packed {
      logic sel;
      logic enable;
      logic write;
      logic [7:0] addr;
      logic [31:0] wdata;
   } tbcc_apb_req_t;

   // Timer event outputs
   typedef struct packed {
      logic captFlag;
      logic captEvent;
      logic running;
   } tbcc_evt_t;
endpackage : tbcc_pkg

// ===== rtl/tbcc_edge_detect.sv
// Edge detector for one synchronous event input
`timescale 1ns/1ps
module tbcc_edge_detect (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Event input and edge outputs
   input wire logic eventIn,
   output logic risePulse,
   output logic fallPulse
);
   logic prev_reg;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         prev_reg <= 1'b0;
      end else begin
         prev_reg <= eventIn;
      end
   end

   assign risePulse = eventIn & ~prev_reg;
   assign fallPulse = ~eventIn & prev_reg;
endmodule : tbcc_edge_detect

// ===== rtl/tbcc_tick_select.sv
// Count tick selection from prescaler outputs
`timescale 1ns/1ps
module tbcc_tick_select (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Selection
   input wire logic [1:0] clockSourceSelect,
   input wire logic partnerTimerTick,
   // Tick output
   output logic countTick
);
   logic div2_reg;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         div2_reg <= 1'b0;
      end else begin
         div2_reg <= ~div2_reg;
      end
   end

   always_comb begin
      case (clockSourceSelect)
         tbcc_pkg::TBCC_PERIPHERAL_CLOCK: countTick = 1'b1;
         tbcc_pkg::TBCC_PERIPHERAL_CLOCK_DIV2: countTick = div2_reg;
         tbcc_pkg::TBCC_CLK_PARTNER: countTick = partnerTimerTick;
         default: countTick = 1'b0;
      endcase
   end
endmodule : tbcc_tick_select

// ===== rtl/tbcc_timer_b.sv
// Timer B capture/compare unit with APB register slave
`timescale 1ns/1ps
module tbcc_timer_b #(
   parameter int COUNT_WIDTH = 16
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Clock and event sources
   input wire logic partnerTimerTick,
   input wire logic eventIn,
   // Waveform pin and port
   input wire logic portOutValue,
   output logic waveformPin,
   output logic waveformPinOe,
   // Timer events
   output tbcc_pkg::tbcc_evt_t timerEvent
);
   logic enable_reg;
   logic [1:0] clock_source_select_reg;
   tbcc_pkg::tbcc_mode_t mode_reg;
   logic waveEn_reg;
   logic waveInit_reg;
   logic edge_reg;
   logic run_reg;
   logic frozen_reg;
   logic capture_flag_reg;
   logic captEvt_reg;
   logic wave_reg;
   logic [COUNT_WIDTH-1:0] count_reg;
   logic [COUNT_WIDTH-1:0] compare_capture_value_reg;
   logic [31:0] prdata_reg;
   logic pslverr_reg;
   logic pinOut_reg;
   logic pinOe_reg;

   logic countTick;
   logic risePulse;
   logic fallPulse;
   logic startEdge;
   logic stopEdge;
   logic captEdge;
   logic wrAccess;
   logic rdAccess;
   logic addrOk;
   logic topHit;
   logic [31:0] rdValue;

   tbcc_tick_select u_tick (
      .ref_clk(ref_clk),
      .rst(rst),
      .clockSourceSelect(clock_source_select_reg),
      .partnerTimerTick(partnerTimerTick),
      .countTick(countTick)
   );

   tbcc_edge_detect u_edge (
      .ref_clk(ref_clk),
      .rst(rst),
      .eventIn(eventIn),
      .risePulse(risePulse),
      .fallPulse(fallPulse)
   );

   // Edge polarity: edge bit 0 starts/captures on rising
   assign startEdge = edge_reg ? fallPulse : risePulse;
   assign stopEdge = edge_reg ? risePulse : fallPulse;
   assign captEdge = edge_reg ? fallPulse : risePulse;

   assign addrOk = (paddr[1:0] == 2'b00) && (paddr <= tbcc_pkg::ADDR_COMPARE_CAPTURE_VALUE);
   assign wrAccess = psel & penable & pwrite & addrOk;
   assign rdAccess = psel & penable & ~pwrite & addrOk;
   // TOP only counts on an enabled tick
   assign topHit = enable_reg && countTick && (count_reg == compare_capture_value_reg);

   // Control registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         enable_reg <= 1'b0;
         clock_source_select_reg <= 2'b00;
         mode_reg <= tbcc_pkg::TBCC_MODE_PERIODIC;
         waveEn_reg <= 1'b0;
         waveInit_reg <= 1'b0;
         edge_reg <= 1'b0;
      end else if (wrAccess) begin
         case (paddr)
            tbcc_pkg::ADDR_CTRL_FIRST: begin
               enable_reg <= pwdata[tbcc_pkg::CF_ENABLE_BIT];
               clock_source_select_reg <= pwdata[tbcc_pkg::CF_CLOCK_SOURCE_SELECT_LSB +: 2];
            end
            tbcc_pkg::ADDR_CTRL_SECOND: begin
               mode_reg <= tbcc_pkg::tbcc_mode_t'(pwdata[tbcc_pkg::CS_MODE_LSB +: 3]);
               waveEn_reg <= pwdata[tbcc_pkg::CS_WAVE_EN_BIT];
               waveInit_reg <= pwdata[tbcc_pkg::CS_WAVE_INIT_BIT];
            end
            tbcc_pkg::ADDR_EVENT_CTRL: begin
               edge_reg <= pwdata[tbcc_pkg::EC_EDGE_BIT];
            end
            default: begin
            end
         endcase
      end
   end

   // Run and freeze state for time-out check
   // Other modes run whenever enabled
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         run_reg <= 1'b0;
         frozen_reg <= 1'b0;
      end else if (!enable_reg) begin
         run_reg <= 1'b0;
         frozen_reg <= 1'b0;
      end else if (mode_reg == tbcc_pkg::TBCC_MODE_TIMEOUT) begin
         if (!run_reg && startEdge) begin
            run_reg <= 1'b1;
            frozen_reg <= 1'b0;
         end else if (run_reg && stopEdge) begin
            run_reg <= 1'b0;
            frozen_reg <= 1'b1;
         end else if (wrAccess && paddr == tbcc_pkg::ADDR_STATUS && !frozen_reg) begin
            run_reg <= pwdata[tbcc_pkg::ST_RUN_BIT];
         end
      end else begin
         run_reg <= 1'b1;
         frozen_reg <= 1'b0;
      end
   end

   // Counter
   // Software count write wins over counting
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         count_reg <= tbcc_pkg::COUNT_RESET;
      end else if (wrAccess && paddr == tbcc_pkg::ADDR_COUNT) begin
         count_reg <= pwdata[COUNT_WIDTH-1:0];
      end else if (enable_reg) begin
         case (mode_reg)
            tbcc_pkg::TBCC_MODE_PERIODIC: begin
               if (countTick) begin
                  // restart at TOP, otherwise step and wrap at MAX
                  count_reg <= (count_reg == compare_capture_value_reg) ? tbcc_pkg::COUNT_BOTTOM
                                                       : count_reg + 1'b1;
               end
            end
            tbcc_pkg::TBCC_MODE_TIMEOUT: begin
               if (!run_reg && startEdge) begin
                  count_reg <= tbcc_pkg::COUNT_BOTTOM;
               end else if (run_reg && countTick) begin
                  count_reg <= (count_reg == compare_capture_value_reg) ? tbcc_pkg::COUNT_BOTTOM
                                                       : count_reg + 1'b1;
               end
            end
            tbcc_pkg::TBCC_MODE_CAPTURE_FLAG_EVT: begin
               if (countTick) begin
                  count_reg <= count_reg + 1'b1;
               end
            end
            default: begin
               if (countTick) begin
                  count_reg <= count_reg + 1'b1;
               end
            end
         endcase
      end
   end

   // Compare/capture value
   // Captured count wins over software write
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         compare_capture_value_reg <= tbcc_pkg::COMPARE_CAPTURE_VALUE_RESET;
      end else if (enable_reg && mode_reg == tbcc_pkg::TBCC_MODE_CAPTURE_FLAG_EVT && captEdge) begin
         compare_capture_value_reg <= count_reg;
      end else if (wrAccess && paddr == tbcc_pkg::ADDR_COMPARE_CAPTURE_VALUE) begin
         compare_capture_value_reg <= pwdata[COUNT_WIDTH-1:0];
      end
   end

   // Capture flag and event; set wins over clear
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         capture_flag_reg <= 1'b0;
         captEvt_reg <= 1'b0;
      end else begin
         captEvt_reg <= 1'b0;
         if (enable_reg && mode_reg == tbcc_pkg::TBCC_MODE_PERIODIC && topHit) begin
            capture_flag_reg <= 1'b1;
            captEvt_reg <= 1'b1;
         end else if (enable_reg && mode_reg == tbcc_pkg::TBCC_MODE_TIMEOUT
                      && run_reg && topHit) begin
            capture_flag_reg <= 1'b1;
            captEvt_reg <= 1'b1;
         end else if (enable_reg && mode_reg == tbcc_pkg::TBCC_MODE_CAPTURE_FLAG_EVT && captEdge) begin
            capture_flag_reg <= 1'b1;
            captEvt_reg <= 1'b1;
         end else if (rdAccess && paddr == tbcc_pkg::ADDR_COMPARE_CAPTURE_VALUE
                      && mode_reg == tbcc_pkg::TBCC_MODE_CAPTURE_FLAG_EVT) begin
            capture_flag_reg <= 1'b0;
         end else if (wrAccess && paddr == tbcc_pkg::ADDR_FLAGS
                      && pwdata[tbcc_pkg::FL_CAPTURE_FLAG_BIT]) begin
            capture_flag_reg <= 1'b0;
         end
      end
   end

   // Waveform: toggled at TOP, loaded with the init value while disabled
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wave_reg <= 1'b0;
      end else if (!enable_reg) begin
         wave_reg <= waveInit_reg;
      end else if (topHit) begin
         wave_reg <= ~wave_reg;
      end
   end

   // Pin drive: timer overrides port value when waveEn_reg is set
   // Pin released during reset, driven in every cycle after it, never released
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pinOut_reg <= 1'b0;
         pinOe_reg <= 1'b0;
      end else begin
         pinOut_reg <= waveEn_reg ? wave_reg : portOutValue;
         pinOe_reg <= 1'b1;
      end
   end

   // Read mux
   always_comb begin
      rdValue = 32'h0000_0000;
      case (paddr)
         tbcc_pkg::ADDR_CTRL_FIRST: begin
            rdValue[tbcc_pkg::CF_ENABLE_BIT] = enable_reg;
            rdValue[tbcc_pkg::CF_CLOCK_SOURCE_SELECT_LSB +: 2] = clock_source_select_reg;
         end
         tbcc_pkg::ADDR_CTRL_SECOND: begin
            rdValue[tbcc_pkg::CS_MODE_LSB +: 3] = mode_reg;
            rdValue[tbcc_pkg::CS_WAVE_EN_BIT] = waveEn_reg;
            rdValue[tbcc_pkg::CS_WAVE_INIT_BIT] = waveInit_reg;
         end
         tbcc_pkg::ADDR_EVENT_CTRL: rdValue[tbcc_pkg::EC_EDGE_BIT] = edge_reg;
         tbcc_pkg::ADDR_STATUS: rdValue[tbcc_pkg::ST_RUN_BIT] = run_reg;
         tbcc_pkg::ADDR_FLAGS: rdValue[tbcc_pkg::FL_CAPTURE_FLAG_BIT] = capture_flag_reg;
         tbcc_pkg::ADDR_COUNT: rdValue[COUNT_WIDTH-1:0] = count_reg;
         tbcc_pkg::ADDR_COMPARE_CAPTURE_VALUE: rdValue[COUNT_WIDTH-1:0] = compare_capture_value_reg;
         default: rdValue = 32'h0000_0000;
      endcase
   end

   // APB response: ready in the first access cycle, no wait state, data registered
   // Read data latched in setup, stands with pready
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pready <= 1'b0;
         prdata_reg <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         prdata_reg <= (psel & ~penable & ~pwrite) ? rdValue : prdata_reg;
         pslverr_reg <= psel & ~penable & ~((paddr[1:0] == 2'b00)
                                           && (paddr <= tbcc_pkg::ADDR_COMPARE_CAPTURE_VALUE));
      end
   end

   assign prdata = prdata_reg;
   assign pslverr = pslverr_reg;
   assign waveformPin = pinOut_reg;
   assign waveformPinOe = pinOe_reg;
   assign timerEvent = '{captFlag: capture_flag_reg, captEvent: captEvt_reg, running: run_reg};
endmodule : tbcc_timer_b

// ===== verif/tbcc_timer_b_props.sv
// Port-level checker for the timer B unit
`timescale 1ns/1ps
module tbcc_timer_b_props (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Pin and events
   input wire logic portOutValue,
   input wire logic waveformPin,
   input wire logic waveformPinOe,
   input wire tbcc_pkg::tbcc_evt_t timerEvent
);
   logic apbWr;
   logic waveOn;
   logic timerOn;
   assign apbWr = psel && penable && pready && pwrite && !pslverr;
   // Shadow of waveform enable
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         waveOn <= 1'h0;
      end else if (apbWr && paddr == tbcc_pkg::ADDR_CTRL_SECOND) begin
         waveOn <= pwdata[tbcc_pkg::CS_WAVE_EN_BIT];
      end
   end
   // Shadow of counter enable
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         timerOn <= 1'h0;
      end else if (apbWr && paddr == tbcc_pkg::ADDR_CTRL_FIRST) begin
         timerOn <= pwdata[tbcc_pkg::CF_ENABLE_BIT];
      end
   end
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   a_ready_single: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_refuse_unmapped: assert property (pready |-> pslverr ==
      (paddr[1:0] != 2'h0 || paddr > tbcc_pkg::ADDR_COMPARE_CAPTURE_VALUE))
      else $error("wrong error response");
   a_event_sets_flag: assert property (timerEvent.captEvent |-> timerEvent.captFlag)
      else $error("event without flag");
   a_flag_sticky: assert property ($fell(timerEvent.captFlag) |->
      $past(psel && penable && (pwrite ? paddr == tbcc_pkg::ADDR_FLAGS && pwdata[0]
      : paddr == tbcc_pkg::ADDR_COMPARE_CAPTURE_VALUE)))
      else $error("flag dropped by itself");
   a_oe_high: assert property (!$past(rst) |-> waveformPinOe)
      else $error("pin not driven");
   a_pin_port: assert property (!waveOn && !$past(waveOn) |->
      waveformPin == $past(portOutValue))
      else $error("pin does not follow port");
   a_idle_quiet: assert property ((!timerOn) [*4] |-> !timerEvent.captEvent)
      else $error("event while disabled");
endmodule : tbcc_timer_b_props

bind tbcc_timer_b tbcc_timer_b_props u_props (
   .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .portOutValue(portOutValue), .waveformPin(waveformPin),
   .waveformPinOe(waveformPinOe), .timerEvent(timerEvent)
);

// ===== verif/tbcc_event_fabric.sv
// Event routing model: event level and partner timer ticks
`timescale 1ns/1ps
module tbcc_event_fabric (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Bench requests
   input wire logic levelReq,
   input wire logic [3:0] tickPeriod,
   // Toward the timer
   output logic eventIn,
   output logic partnerTimerTick
);
   logic [1:0] holdCnt;
   logic [3:0] tickCnt;
   // Level moves only after three cycles held
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         eventIn <= 1'h0;
         holdCnt <= 2'h0;
      end else if (levelReq != eventIn && holdCnt == 2'h2) begin
         eventIn <= levelReq;
         holdCnt <= 2'h0;
      end else if (holdCnt != 2'h2) begin
         holdCnt <= holdCnt + 2'h1;
      end
   end
   // One pulse per partner tick
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         tickCnt <= 4'h0;
         partnerTimerTick <= 1'h0;
      end else begin
         tickCnt <= (tickCnt + 4'h1 >= tickPeriod) ? 4'h0 : tickCnt + 4'h1;
         partnerTimerTick <= tickPeriod != 4'h0 && tickCnt == 4'h0;
      end
   end
endmodule : tbcc_event_fabric

// ===== verif/tb.sv
// Self-checking bench for the timer B unit
`timescale 1ns/1ps
module tb;
   logic ref_clk = 1'h0;
   logic rst = 1'h1;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic partnerTimerTick;
   logic eventIn;
   logic levelReq = 1'h0;
   logic portOutValue = 1'h0;
   logic waveformPin;
   logic waveformPinOe;
   tbcc_pkg::tbcc_evt_t timerEvent;
   logic [31:0] rdata;
   logic [31:0] cnt;
   logic lastErr;
   logic w;
   int fails = 0;
   int samplesChecked = 0;
   int gap;
   int div[3] = '{1, 2, 4};
   always #2.5 ref_clk = ~ref_clk;
   tbcc_timer_b DUT (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .partnerTimerTick(partnerTimerTick), .eventIn(eventIn),
      .portOutValue(portOutValue), .waveformPin(waveformPin),
      .waveformPinOe(waveformPinOe), .timerEvent(timerEvent));
   tbcc_event_fabric fabric (.ref_clk(ref_clk), .rst(rst), .levelReq(levelReq),
      .tickPeriod(4'h4), .eventIn(eventIn), .partnerTimerTick(partnerTimerTick));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'h1;
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'h1);
      rdata = prdata;
      lastErr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'h1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      xfer(1'h0, a, 32'h0);
   endtask : rd
   task automatic wait_evt(input int lim, output int n);
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (timerEvent.captEvent !== 1'h1 && n < lim);
   endtask : wait_evt
   task automatic t_reset();
      rd(tbcc_pkg::ADDR_CTRL_SECOND);
      chk(rdata, 32'h0);
      rd(tbcc_pkg::ADDR_COUNT);
      chk(rdata, 32'h0);
      wr(8'h1c, 32'hffffffff);
      chk(32'(lastErr), 32'h1);
      rd(8'h02);
      chk({lastErr, rdata[30:0]}, 32'h80000000);
      wr(tbcc_pkg::ADDR_CTRL_SECOND, 32'h27);
      rd(tbcc_pkg::ADDR_CTRL_SECOND);
      chk(rdata, 32'h27);
      wr(tbcc_pkg::ADDR_CTRL_SECOND, 32'h0);
   endtask : t_reset
   task automatic t_periodic();
      wr(tbcc_pkg::ADDR_COMPARE_CAPTURE_VALUE, 32'h9);
      wr(tbcc_pkg::ADDR_CTRL_SECOND, 32'h10);
      for (int s = 0; s < 3; s++) begin
         wr(tbcc_pkg::ADDR_CTRL_FIRST, {29'h0, s[1:0], 1'h1});
         wait_evt(200, gap);
         wait_evt(200, gap);
         chk(gap, 10 * div[s]);
         repeat (3) @(posedge ref_clk);
         w = waveformPin;
         wait_evt(200, gap);
         repeat (3) @(posedge ref_clk);
         chk(32'(waveformPin), {31'h0, ~w});
      end
      wr(tbcc_pkg::ADDR_CTRL_FIRST, 32'h0);
      rd(tbcc_pkg::ADDR_FLAGS);
      chk(rdata, 32'h1);
      wr(tbcc_pkg::ADDR_FLAGS, 32'h1);
      rd(tbcc_pkg::ADDR_FLAGS);
      chk(rdata, 32'h0);
      wr(tbcc_pkg::ADDR_CTRL_SECOND, 32'h0);
      portOutValue <= 1'h1;
      repeat (3) @(posedge ref_clk);
      chk(32'(waveformPin), 32'h1);
      wr(tbcc_pkg::ADDR_COMPARE_CAPTURE_VALUE, 32'h10);
      wr(tbcc_pkg::ADDR_COUNT, 32'hfff0);
      wr(tbcc_pkg::ADDR_CTRL_FIRST, 32'h1);
      wait_evt(60, gap);
      chk(gap, 34);
   endtask : t_periodic
   task automatic t_timeout();
      wr(tbcc_pkg::ADDR_CTRL_FIRST, 32'h0);
      wr(tbcc_pkg::ADDR_COMPARE_CAPTURE_VALUE, 32'h18);
      wr(tbcc_pkg::ADDR_EVENT_CTRL, 32'h0);
      wr(tbcc_pkg::ADDR_CTRL_SECOND, 32'h1);
      wr(tbcc_pkg::ADDR_FLAGS, 32'h1);
      wr(tbcc_pkg::ADDR_CTRL_FIRST, 32'h1);
      levelReq <= 1'h1;
      repeat (8) @(posedge ref_clk);
      chk(32'(timerEvent.running), 32'h1);
      levelReq <= 1'h0;
      repeat (6) @(posedge ref_clk);
      chk(32'(timerEvent.running), 32'h0);
      rd(tbcc_pkg::ADDR_COUNT);
      cnt = rdata;
      rd(tbcc_pkg::ADDR_COMPARE_CAPTURE_VALUE);
      chk(rdata, 32'h18);
      wr(tbcc_pkg::ADDR_STATUS, 32'h1);
      rd(tbcc_pkg::ADDR_COUNT);
      chk(rdata, cnt);
      rd(tbcc_pkg::ADDR_FLAGS);
      chk(rdata, 32'h0);
      levelReq <= 1'h1;
      wait_evt(60, gap);
      chk(gap, 28);
   endtask : t_timeout
   task automatic t_capture();
      wr(tbcc_pkg::ADDR_CTRL_FIRST, 32'h0);
      levelReq <= 1'h0;
      wr(tbcc_pkg::ADDR_COUNT, 32'h0);
      wr(tbcc_pkg::ADDR_CTRL_SECOND, 32'h2);
      wr(tbcc_pkg::ADDR_FLAGS, 32'h1);
      wr(tbcc_pkg::ADDR_CTRL_FIRST, 32'h1);
      repeat (20) @(posedge ref_clk);
      levelReq <= 1'h1;
      wait_evt(10, gap);
      rd(tbcc_pkg::ADDR_FLAGS);
      chk(rdata, 32'h1);
      rd(tbcc_pkg::ADDR_COUNT);
      cnt = rdata;
      rd(tbcc_pkg::ADDR_COMPARE_CAPTURE_VALUE);
      chk(32'(rdata >= 32'd20 && rdata < cnt), 32'h1);
      rd(tbcc_pkg::ADDR_FLAGS);
      chk(rdata, 32'h0);
      levelReq <= 1'h0;
      wait_evt(10, gap);
      chk(gap, 10);
      wr(tbcc_pkg::ADDR_EVENT_CTRL, 32'h10);
      levelReq <= 1'h1;
      wait_evt(10, gap);
      chk(gap, 10);
      levelReq <= 1'h0;
      wait_evt(10, gap);
      chk(gap, 3);
   endtask : t_capture
   task automatic close_out();
      if (fails == 0 && samplesChecked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : close_out
   initial begin
      #200000;
      fails++;
      close_out();
   end
   initial begin
      repeat (16) @(posedge ref_clk);
      rst <= 1'h0;
      t_reset();
      t_periodic();
      t_timeout();
      t_capture();
      close_out();
   end
endmodule : tb
